// ===== common/apg_pkg.sv
`default_nettype none
package apg_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int APG_DW = 16;
   localparam logic APG_REG_IND_ADDR = 1'b0;
   localparam logic APG_REG_IND_DATA = 1'b1;
   localparam int APG_IA_BUSY = 15;
   localparam int APG_IA_RWB = 14;
   localparam int APG_IA_LOC_LSB = 6;
   localparam int APG_IA_PATH_LSB = 0;
   localparam logic [15:0] APG_ZERO16 = 16'h0000;

   // Indirect locations
   localparam logic [3:0] APG_LOC_RX_OH = 4'h5;
   localparam logic [3:0] APG_LOC_GEN_CFG = 4'h8;
   localparam logic [3:0] APG_LOC_STATE_HI = 4'h9;
   localparam logic [3:0] APG_LOC_STATE_LO = 4'hA;
   localparam logic [3:0] APG_LOC_B1_VAL = 4'hB;

   // generator_path_config fields
   localparam int APG_CFG_AUTO = 0;
   localparam int APG_CFG_INV = 1;
   localparam int APG_CFG_FORCE = 3;
   localparam int APG_CFG_REPL = 4;
   localparam int APG_CFG_SEQ = 5;
   localparam int APG_CFG_SS_LSB = 6;
   localparam int APG_CFG_AIS_IGN = 8;
   localparam int APG_CFG_ENA = 12;
   localparam logic [15:0] APG_CFG_RW_MASK = 16'h33F3;
   localparam logic [15:0] APG_CFG_RESET = 16'h0000;

   // Pattern generator
   localparam int APG_PRBS_LEN = 23;
   localparam int APG_PRBS_TAP_A = 22;
   localparam int APG_PRBS_TAP_B = 17;
   localparam int APG_STATE_HI_LSB = 7;
   localparam logic [22:0] APG_PRBS_RESET = 23'h00_0000;
   localparam logic [7:0] APG_ERR_MASK = 8'h80;
   localparam int APG_H1_SS_LSB = 2;

   // Autonomous frame geometry, byte interleaved paths
   localparam int APG_NUM_PATHS = 12;
   localparam int APG_GROUPS = 90;
   localparam int APG_ROWS = 9;
   localparam int APG_TOH_GROUPS = 3;
   localparam int APG_POH_GROUP = 3;
   localparam int APG_ROW_B1E1 = 1;
   localparam int APG_ROW_H1 = 3;
   localparam int APG_GRP_B1 = 0;
   localparam int APG_GRP_E1 = 1;
   localparam int APG_GRP_H1 = 0;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      APG_KIND_TOH, APG_KIND_POH, APG_KIND_PAYLOAD,
      APG_KIND_B1, APG_KIND_E1, APG_KIND_H1
   } apg_kind_t;

   typedef struct packed {
      logic valid;
      logic [3:0] path;
      apg_kind_t kind;
      logic [7:0] data;
   } apg_slot_t;

   typedef struct packed {
      logic rwb;
      logic [3:0] loc;
      logic [3:0] path;
   } apg_access_t;

   typedef enum logic {APG_IA_IDLE, APG_IA_XFER} apg_ia_state_t;
endpackage : apg_pkg
`default_nettype wire

// ===== logic/apg_add_pattern_gen_mon.sv
`timescale 1ns/1ps
`default_nettype none
module apg_add_pattern_gen_mon #(
   parameter int NUM_PATHS = apg_pkg::APG_NUM_PATHS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire logic regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [apg_pkg::APG_DW-1:0] regWdata,
   output logic [apg_pkg::APG_DW-1:0] regRdata,
   // Add bus in, transmit path out
   input wire apg_pkg::apg_slot_t addSlot,
   input wire logic [NUM_PATHS-1:0] concatSlave,
   output apg_pkg::apg_slot_t txSlot,
   // Pins
   input wire logic addFramePulseInput,
   input wire logic [NUM_PATHS-1:0] externalAisRequest,
   output logic [NUM_PATHS-1:0] aisInsert
);
   import apg_pkg::*;

   function automatic logic [22:0] prbsStep8(input logic [22:0] s);
      logic [22:0] t;
      t = s;
      for (int i = 0; i < 8; i++) begin
         t = {t[APG_PRBS_LEN-2:0], t[APG_PRBS_TAP_A] ^ t[APG_PRBS_TAP_B]};
      end
      return t;
   endfunction : prbsStep8

   function automatic logic pathOk(input logic [3:0] p);
      return (p != 4'h0) && (int'(p) <= NUM_PATHS);
   endfunction : pathOk

   ////////////////////////////////////////////////////////////////////////
   // Per-path storage
   logic [15:0] cfg_r [NUM_PATHS];
   logic [22:0] lfsr_r [NUM_PATHS];
   logic [7:0] seqCnt_r [NUM_PATHS];
   logic [7:0] b1Val_r [NUM_PATHS];
   logic [7:0] recB1_r [NUM_PATHS];
   logic [7:0] recE1_r [NUM_PATHS];
   logic [NUM_PATHS-1:0] forceErr_r;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic fpMeta_r, fpSync_r, fpDly_r;
   logic [NUM_PATHS-1:0] aisMeta_r, aisSync_r;
   logic frameStart;

   always_ff @(posedge mclk) begin
      if (reset) begin
         fpMeta_r <= 1'b0;
         fpSync_r <= 1'b0;
         fpDly_r <= 1'b0;
         aisMeta_r <= '0;
         aisSync_r <= '0;
      end else begin
         fpMeta_r <= addFramePulseInput;
         fpSync_r <= fpMeta_r;
         fpDly_r <= fpSync_r;
         aisMeta_r <= externalAisRequest;
         aisSync_r <= aisMeta_r;
      end
   end

   assign frameStart = fpSync_r & ~fpDly_r;

   ////////////////////////////////////////////////////////////////////////
   // Autonomous frame position, restarted by the J0 pulse
   logic [3:0] slotCnt_r;
   logic [6:0] groupCnt_r;
   logic [3:0] rowCnt_r;

   always_ff @(posedge mclk) begin
      if (reset || frameStart) begin
         slotCnt_r <= '0;
         groupCnt_r <= '0;
         rowCnt_r <= '0;
      end else if (int'(slotCnt_r) != NUM_PATHS - 1) begin
         slotCnt_r <= slotCnt_r + 4'd1;
      end else begin
         slotCnt_r <= '0;
         if (int'(groupCnt_r) != APG_GROUPS - 1) begin
            groupCnt_r <= groupCnt_r + 7'd1;
         end else begin
            groupCnt_r <= '0;
            rowCnt_r <= (int'(rowCnt_r) == APG_ROWS - 1) ? 4'd0 :
                        rowCnt_r + 4'd1;
         end
      end
   end

   apg_kind_t autoKind;
   always_comb begin
      if (int'(groupCnt_r) == APG_POH_GROUP) begin
         autoKind = APG_KIND_POH;
      end else if (int'(groupCnt_r) >= APG_TOH_GROUPS) begin
         autoKind = APG_KIND_PAYLOAD;
      end else if (int'(rowCnt_r) == APG_ROW_B1E1 &&
                   int'(groupCnt_r) == APG_GRP_B1) begin
         autoKind = APG_KIND_B1;
      end else if (int'(rowCnt_r) == APG_ROW_B1E1 &&
                   int'(groupCnt_r) == APG_GRP_E1) begin
         autoKind = APG_KIND_E1;
      end else if (int'(rowCnt_r) == APG_ROW_H1 &&
                   int'(groupCnt_r) == APG_GRP_H1) begin
         autoKind = APG_KIND_H1;
      end else begin
         autoKind = APG_KIND_TOH;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte slot processing
   logic [3:0] autoPath;
   logic autoSel, curOk, advance, applyErr;
   apg_slot_t cur, nxt;
   int unsigned idx;
   logic [15:0] curCfg;
   logic [7:0] pattern, patOut;
   logic [22:0] lfsrNxt;

   assign autoPath = slotCnt_r + 4'd1;

   always_comb begin
      autoSel = cfg_r[int'(slotCnt_r)][APG_CFG_AUTO];
      cur = addSlot;
      if (autoSel) begin
         cur.valid = 1'b1;
         cur.path = autoPath;
         cur.kind = autoKind;
         cur.data = 8'h00;
      end
      curOk = cur.valid && pathOk(cur.path);
      idx = curOk ? int'(cur.path) - 1 : 0;
      curCfg = cfg_r[idx];
      lfsrNxt = prbsStep8(lfsr_r[idx]);
      pattern = curCfg[APG_CFG_SEQ] ? seqCnt_r[idx] : lfsrNxt[7:0];
      advance = curOk && cur.kind == APG_KIND_PAYLOAD &&
                curCfg[APG_CFG_ENA];
      applyErr = advance && forceErr_r[idx];
      patOut = pattern ^ {8{curCfg[APG_CFG_INV]}};
      if (applyErr) begin
         patOut = patOut ^ APG_ERR_MASK;
      end
      nxt = cur;
      if (curOk) begin
         case (cur.kind)
            APG_KIND_PAYLOAD: begin
               if (advance) begin
                  nxt.data = patOut;
               end
            end
            // Independent of the insert enable on purpose
            APG_KIND_B1: begin
               if (curCfg[APG_CFG_REPL]) begin
                  nxt.data = b1Val_r[idx];
               end
            end
            APG_KIND_E1: begin
               if (curCfg[APG_CFG_REPL]) begin
                  nxt.data = ~b1Val_r[idx];
               end
            end
            APG_KIND_H1: begin
               if (autoSel && concatSlave[idx]) begin
                  nxt.data[APG_H1_SS_LSB +: 2] =
                     curCfg[APG_CFG_SS_LSB +: 2];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         txSlot <= '0;
      end else begin
         txSlot <= nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         aisInsert <= '0;
      end else begin
         for (int p = 0; p < NUM_PATHS; p++) begin
            aisInsert[p] <= aisSync_r[p] &
                            ~cfg_r[p][APG_CFG_AIS_IGN];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indirect access
   apg_ia_state_t iaState_r;
   apg_access_t iaReq_r;
   logic [15:0] dataReg_r;
   logic xferWr, xferRd;
   int unsigned reqIdx;

   always_ff @(posedge mclk) begin
      if (reset) begin
         iaState_r <= APG_IA_IDLE;
         iaReq_r <= '0;
      end else begin
         case (iaState_r)
            APG_IA_IDLE: begin
               if (regWrite && regAddr == APG_REG_IND_ADDR) begin
                  iaReq_r.rwb <= regWdata[APG_IA_RWB];
                  iaReq_r.loc <= regWdata[APG_IA_LOC_LSB +: 4];
                  iaReq_r.path <= regWdata[APG_IA_PATH_LSB +: 4];
                  iaState_r <= APG_IA_XFER;
               end
            end
            APG_IA_XFER: begin
               iaState_r <= APG_IA_IDLE;
            end
            default: begin
               iaState_r <= APG_IA_IDLE;
            end
         endcase
      end
   end

   assign xferWr = iaState_r == APG_IA_XFER && !iaReq_r.rwb &&
                   pathOk(iaReq_r.path);
   assign xferRd = iaState_r == APG_IA_XFER && iaReq_r.rwb;
   assign reqIdx = pathOk(iaReq_r.path) ? int'(iaReq_r.path) - 1 : 0;

   logic [15:0] locData;
   always_comb begin
      locData = APG_ZERO16;
      if (pathOk(iaReq_r.path)) begin
         case (iaReq_r.loc)
            APG_LOC_RX_OH: locData = {recE1_r[reqIdx], recB1_r[reqIdx]};
            // Error inject is never stored in cfg_r, so it reads zero
            APG_LOC_GEN_CFG: locData = cfg_r[reqIdx];
            APG_LOC_STATE_HI: begin
               locData = lfsr_r[reqIdx][APG_PRBS_LEN-1:APG_STATE_HI_LSB];
            end
            APG_LOC_STATE_LO: begin
               locData = {9'h000, lfsr_r[reqIdx][APG_STATE_HI_LSB-1:0]};
            end
            APG_LOC_B1_VAL: locData = {8'h00, b1Val_r[reqIdx]};
            default: locData = APG_ZERO16;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dataReg_r <= APG_ZERO16;
      end else if (xferRd) begin
         dataReg_r <= locData;
      end else if (regWrite && regAddr == APG_REG_IND_DATA) begin
         dataReg_r <= regWdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdata <= APG_ZERO16;
      end else if (regRead) begin
         if (regAddr == APG_REG_IND_DATA) begin
            regRdata <= dataReg_r;
         end else begin
            regRdata <= APG_ZERO16;
            regRdata[APG_IA_BUSY] <= iaState_r == APG_IA_XFER;
            regRdata[APG_IA_RWB] <= iaReq_r.rwb;
            regRdata[APG_IA_LOC_LSB +: 4] <= iaReq_r.loc;
            regRdata[APG_IA_PATH_LSB +: 4] <= iaReq_r.path;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-path state updates
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PATHS; p++) begin
         if (reset) begin
            cfg_r[p] <= APG_CFG_RESET;
            b1Val_r[p] <= 8'h00;
         end else if (xferWr && reqIdx == p) begin
            if (iaReq_r.loc == APG_LOC_GEN_CFG) begin
               cfg_r[p] <= dataReg_r & APG_CFG_RW_MASK;
            end
            if (iaReq_r.loc == APG_LOC_B1_VAL) begin
               b1Val_r[p] <= dataReg_r[7:0];
            end
         end
      end
   end

   // A software load wins over the byte advance in the same cycle
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PATHS; p++) begin
         if (reset) begin
            lfsr_r[p] <= APG_PRBS_RESET;
            seqCnt_r[p] <= 8'h00;
         end else if (xferWr && reqIdx == p &&
                      iaReq_r.loc == APG_LOC_STATE_HI) begin
            lfsr_r[p][APG_PRBS_LEN-1:APG_STATE_HI_LSB] <= dataReg_r;
         end else if (xferWr && reqIdx == p &&
                      iaReq_r.loc == APG_LOC_STATE_LO) begin
            lfsr_r[p][APG_STATE_HI_LSB-1:0] <=
               dataReg_r[APG_STATE_HI_LSB-1:0];
         end else if (advance && idx == p) begin
            if (curCfg[APG_CFG_SEQ]) begin
               seqCnt_r[p] <= seqCnt_r[p] + 8'd1;
            end else begin
               lfsr_r[p] <= lfsrNxt;
            end
         end
      end
   end

   // Set by the write wins over the clear by use
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PATHS; p++) begin
         if (reset) begin
            forceErr_r[p] <= 1'b0;
         end else if (xferWr && reqIdx == p &&
                      iaReq_r.loc == APG_LOC_GEN_CFG &&
                      dataReg_r[APG_CFG_FORCE]) begin
            forceErr_r[p] <= 1'b1;
         end else if (applyErr && idx == p) begin
            forceErr_r[p] <= 1'b0;
         end
      end
   end

   // Capture from the add bus, whatever mode the generator is in
   always_ff @(posedge mclk) begin
      for (int p = 0; p < NUM_PATHS; p++) begin
         if (reset) begin
            recB1_r[p] <= 8'h00;
            recE1_r[p] <= 8'h00;
         end else if (addSlot.valid && pathOk(addSlot.path) &&
                      int'(addSlot.path) == p + 1) begin
            if (addSlot.kind == APG_KIND_B1) begin
               recB1_r[p] <= addSlot.data;
            end
            if (addSlot.kind == APG_KIND_E1) begin
               recE1_r[p] <= addSlot.data;
            end
         end
      end
   end
endmodule : apg_add_pattern_gen_mon
`default_nettype wire

// ===== dv/apg_add_pattern_gen_mon_properties.sv
`timescale 1ns/1ps
`default_nettype none
module apg_add_pattern_gen_mon_properties #(
   parameter int NUM_PATHS = apg_pkg::APG_NUM_PATHS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire logic regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [apg_pkg::APG_DW-1:0] regWdata,
   input wire logic [apg_pkg::APG_DW-1:0] regRdata,
   // Stream
   input wire apg_pkg::apg_slot_t addSlot,
   input wire logic [NUM_PATHS-1:0] concatSlave,
   input wire apg_pkg::apg_slot_t txSlot,
   // Pins
   input wire logic addFramePulseInput,
   input wire logic [NUM_PATHS-1:0] externalAisRequest,
   input wire logic [NUM_PATHS-1:0] aisInsert
);
   import apg_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic passKind;
   logic badPath;
   logic autoAny;
   logic [NUM_PATHS-1:0] autoCfg_r, autoDly_r;
   logic [APG_DW-1:0] swData_r;
   // Autonomous paths take over bus slots, so the pass checks stand down
   assign passKind = addSlot.kind inside {APG_KIND_TOH, APG_KIND_POH,
                                          APG_KIND_H1};
   assign badPath = addSlot.path == 4'h0 || addSlot.path > NUM_PATHS;
   // Software view of the mode bits; the delayed copy covers the cycle
   // in which a cleared bit has not yet reached the generator
   always_ff @(posedge mclk) begin
      if (reset) begin
         autoCfg_r <= '0;
         autoDly_r <= '0;
         swData_r <= '0;
      end else begin
         autoDly_r <= autoCfg_r;
         if (regWrite && regAddr == APG_REG_IND_DATA) begin
            swData_r <= regWdata;
         end
         if (regWrite && regAddr == APG_REG_IND_ADDR &&
             !regWdata[APG_IA_RWB] &&
             regWdata[APG_IA_LOC_LSB +: 4] == APG_LOC_GEN_CFG &&
             regWdata[APG_IA_PATH_LSB +: 4] != 4'h0 &&
             int'(regWdata[APG_IA_PATH_LSB +: 4]) <= NUM_PATHS) begin
            autoCfg_r[regWdata[APG_IA_PATH_LSB +: 4] - 4'd1] <=
               swData_r[APG_CFG_AUTO];
         end
      end
   end
   assign autoAny = |(autoCfg_r | autoDly_r);
   ////////////////////////////////////////////////////////////////////////
   sequence s_pass;
      addSlot.valid && !autoAny && (passKind || badPath);
   endsequence
   property p_pass;
      s_pass |=> txSlot == $past(addSlot);
   endproperty
   a_pass: assert property (p_pass)
      else $error("overhead or stray byte altered");
   property p_shape;
      addSlot.valid && !autoAny |=> txSlot.valid &&
         txSlot.path == $past(addSlot.path) &&
         txSlot.kind == $past(addSlot.kind);
   endproperty
   a_shape: assert property (p_shape)
      else $error("output slot lost its path or kind");
   property p_idle;
      !addSlot.valid && !autoAny |=> !txSlot.valid;
   endproperty
   a_idle: assert property (p_idle)
      else $error("slot appeared from an idle bus");
   property p_rdHold;
      !regRead |=> $stable(regRdata);
   endproperty
   a_rdHold: assert property (p_rdHold)
      else $error("read data moved without a read");
   property p_aisQuiet;
      (externalAisRequest == '0) [*4] |-> aisInsert == '0;
   endproperty
   a_aisQuiet: assert property (p_aisQuiet)
      else $error("alarm inserted with no request");
   property p_aisFollow;
      $stable(externalAisRequest) [*4] |->
         (aisInsert & ~externalAisRequest) == '0;
   endproperty
   a_aisFollow: assert property (p_aisFollow)
      else $error("alarm outlives its request");
   // Two synchroniser stages and the output flop: three cycles of lag
   property p_aisCause;
      ((aisInsert & ~$past(aisInsert)) & ~$past(externalAisRequest, 3)) == '0;
   endproperty
   a_aisCause: assert property (p_aisCause)
      else $error("alarm rose without an earlier request");
   property p_rstOut;
      disable iff (1'b0) reset |=> !txSlot.valid && aisInsert == '0;
   endproperty
   a_rstOut: assert property (p_rstOut) // Slot valid and alarm outputs quiet under reset
      else $error("output active during reset");
   c_payload: cover property (addSlot.valid
      && addSlot.kind == APG_KIND_PAYLOAD ##1 txSlot.valid);
   c_read: cover property (regRead ##1 regRdata != '0);
   c_ais: cover property (aisInsert != '0);
   c_autoH1: cover property (txSlot.valid && txSlot.kind == APG_KIND_H1);
endmodule : apg_add_pattern_gen_mon_properties
`default_nettype wire

// ===== dv/apg_add_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module apg_add_bus_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Add bus toward the generator
   output var apg_pkg::apg_slot_t addSlot,
   output var logic framePulse
);
   import apg_pkg::*;
   initial begin
      addSlot = '0;
      framePulse = 1'b0;
   end
   // Idle bus shows the inverse of the last byte so stale data never passes
   task automatic put(input logic [3:0] p, input apg_kind_t k,
                      input logic [7:0] d);
      @(negedge mclk);
      addSlot = '{valid: 1'b1, path: p, kind: k, data: d};
      @(negedge mclk);
      addSlot.valid = 1'b0;
      addSlot.data = ~d;
   endtask : put
   // A clean pulse keeps framing valid, so no masking is needed
   task automatic pulse;
      @(negedge mclk);
      framePulse = 1'b1;
      repeat (2) @(negedge mclk);
      framePulse = 1'b0;
   endtask : pulse
endmodule : apg_add_bus_model
`default_nettype wire

// ===== dv/apg_add_pattern_gen_mon_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module apg_add_pattern_gen_mon_test;
   import apg_pkg::*;
   localparam int NP = APG_NUM_PATHS;
   logic mclk, reset, regAddr, regWrite, regRead, fp;
   logic [APG_DW-1:0] regWdata, regRdata, rd;
   apg_slot_t addSlot, txSlot;
   logic [NP-1:0] concatSlave, aisReq, aisInsert;
   logic [22:0] st;
   logic [7:0] ex;
   int fails, checked, cyc;
   logic [3:0] locs [4] = '{APG_LOC_GEN_CFG, APG_LOC_STATE_HI,
                            APG_LOC_STATE_LO, APG_LOC_B1_VAL};
   logic [15:0] wdat [4] = '{16'h11FA, 16'hABCD, 16'h00FF, 16'h00A5};
   logic [15:0] rexp [4] = '{16'h11F2, 16'hABCD, 16'h007F, 16'h00A5};
   apg_add_bus_model bus (.mclk(mclk), .reset(reset), .addSlot(addSlot),
                          .framePulse(fp));
   apg_add_pattern_gen_mon #(.NUM_PATHS(NP)) DUT (.mclk(mclk),
      .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
      .addSlot(addSlot), .concatSlave(concatSlave), .txSlot(txSlot),
      .addFramePulseInput(fp), .externalAisRequest(aisReq),
      .aisInsert(aisInsert));
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic wr(input logic a, input logic [15:0] d);
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge mclk);
      regWrite = 1'b0;
   endtask : wr
   task automatic iwr(input logic [3:0] loc, p, input logic [15:0] d);
      wr(1'b1, d);
      wr(1'b0, {6'h00, loc, 2'b00, p});
      repeat (2) @(negedge mclk);
   endtask : iwr
   task automatic ird(input logic [3:0] loc, p);
      wr(1'b0, {6'h10, loc, 2'b00, p});
      repeat (2) @(negedge mclk);
      regAddr = 1'b1;
      regRead = 1'b1;
      @(negedge mclk);
      regRead = 1'b0;
      rd = regRdata;
   endtask : ird
   task automatic xfer(input logic [3:0] p, input apg_kind_t k,
                       input logic [7:0] d, e);
      bus.put(p, k, d);
      `CHK("txData", e, txSlot.data)
   endtask : xfer
   function automatic logic [22:0] step(input logic [22:0] s);
      for (int i = 0; i < 8; i++)
         s = {s[21:0], s[22] ^ s[17]};
      return s;
   endfunction : step
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      reset = 1'b1;
      {regAddr, regWrite, regRead} = 3'h0;
      regWdata = 16'h0000;
      concatSlave = '0;
      aisReq = '0;
      fails = 0;
      checked = 0;
      cyc = 0;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      bus.pulse();
      // Reset value, write and readback on the last path
      for (int i = 0; i < 4; i++) begin
         ird(locs[i], 4'd12);
         `CHK("regReset", 16'h0000, rd)
         iwr(locs[i], 4'd12, wdat[i]);
         ird(locs[i], 4'd12);
         `CHK("regRw", rexp[i], rd)
      end
      ird(APG_LOC_GEN_CFG, 4'd11);
      `CHK("otherPath", 16'h0000, rd)
      iwr(APG_LOC_GEN_CFG, 4'd0, 16'h1000);
      ird(APG_LOC_GEN_CFG, 4'd0);
      `CHK("badPath", 16'h0000, rd)
      ird(4'hC, 4'd1);
      `CHK("unusedLoc", 16'h0000, rd)
      // PRBS from a loaded state, then invert, then one forced error
      st = 23'h5A_1C3E;
      iwr(APG_LOC_STATE_HI, 4'd1, st[22:7]);
      iwr(APG_LOC_STATE_LO, 4'd1, {9'h000, st[6:0]});
      iwr(APG_LOC_GEN_CFG, 4'd1, 16'h1000);
      for (int i = 0; i < 6; i++) begin
         if (i == 2) iwr(APG_LOC_GEN_CFG, 4'd1, 16'h1002);
         if (i == 4) iwr(APG_LOC_GEN_CFG, 4'd1, 16'h100A);
         st = step(st);
         ex = st[7:0] ^ ((i >= 2) ? 8'hFF : 8'h00);
         if (i == 4) ex = ex ^ APG_ERR_MASK;
         xfer(4'd1, APG_KIND_PAYLOAD, 8'h33, ex);
      end
      xfer(4'd1, APG_KIND_POH, 8'h77, 8'h77);
      ird(APG_LOC_GEN_CFG, 4'd1);
      `CHK("forceClr", 16'h1002, rd)
      ird(APG_LOC_STATE_HI, 4'd1);
      `CHK("stateHi", st[22:7], rd)
      ird(APG_LOC_STATE_LO, 4'd1);
      `CHK("stateLo", {9'h000, st[6:0]}, rd)
      // Sequential count on a fresh path
      iwr(APG_LOC_GEN_CFG, 4'd2, 16'h1020);
      for (int i = 0; i < 3; i++)
         xfer(4'd2, APG_KIND_PAYLOAD, 8'hEE, 8'(i));
      // Replacement without insertion, then both off
      iwr(APG_LOC_B1_VAL, 4'd3, 16'h003C);
      iwr(APG_LOC_GEN_CFG, 4'd3, 16'h0010);
      xfer(4'd3, APG_KIND_B1, 8'h11, 8'h3C);
      xfer(4'd3, APG_KIND_E1, 8'h22, 8'hC3);
      xfer(4'd3, APG_KIND_PAYLOAD, 8'h44, 8'h44);
      iwr(APG_LOC_GEN_CFG, 4'd3, 16'h0000);
      xfer(4'd3, APG_KIND_B1, 8'h11, 8'h11);
      // Received overhead capture
      xfer(4'd4, APG_KIND_B1, 8'h5A, 8'h5A);
      xfer(4'd4, APG_KIND_E1, 8'h96, 8'h96);
      ird(APG_LOC_RX_OH, 4'd4);
      `CHK("rxOh", 16'h965A, rd)
      // Path 12 ignores its request
      aisReq = '1;
      repeat (5) @(negedge mclk);
      `CHK("aisOn", 12'h7FF, aisInsert)
      aisReq = '0;
      repeat (5) @(negedge mclk);
      `CHK("aisOff", 12'h000, aisInsert)
      // Autonomous path 5, sequential, SS 2 in its concatenated H1.
      // The frame restarts three edges after the pulse; position q
      // then shows on txSlot q + 2 falling edges after the pulse task.
      concatSlave = 12'h010;
      iwr(APG_LOC_GEN_CFG, 4'd5, 16'h10A1);
      bus.pulse();
      repeat (54) @(negedge mclk);
      `CHK("autoPos", {1'b1, 4'd5, APG_KIND_PAYLOAD}, txSlot[15:8])
      rd = {8'h00, txSlot.data};
      repeat (12) @(negedge mclk);
      `CHK("autoSeq", rd[7:0] + 8'h01, txSlot.data)
      repeat (3180) @(negedge mclk);
      `CHK("autoH1", {APG_KIND_H1, 8'h08}, txSlot[10:0])
      conclude();
   end
endmodule : apg_add_pattern_gen_mon_test
bind apg_add_pattern_gen_mon apg_add_pattern_gen_mon_properties #(
   .NUM_PATHS(NUM_PATHS)) u_props (.mclk(mclk), .reset(reset),
   .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regWdata(regWdata), .regRdata(regRdata), .addSlot(addSlot),
   .concatSlave(concatSlave), .txSlot(txSlot),
   .addFramePulseInput(addFramePulseInput),
   .externalAisRequest(externalAisRequest), .aisInsert(aisInsert));
`default_nettype wire
